// file: verilog/bbi_seq.v
// Purpose: Sequencer timing bit and branch instructions byte by byte
// Assumes: code_data shows the byte at code_addr in the same cycle
// Notes: Datapath writes leave one cycle after the decision, registered
//
// Behaviour
// - Bit AND into carry, true or inverted bit: two bytes, two cycles.
// - Bit OR into carry, true or inverted bit: two bytes, two cycles.
// - Bit copy either way between carry and direct bit: two bytes, two cycles.
// - Branch on carry set or clear: two bytes, two or three cycles.
// - Branch on direct bit set or clear: three bytes, three or four cycles.
// - Test-and-clear branch jumps on set bit, clears it: three bytes, 3/4 cycles.
// - Short relative jump: two bytes, always three cycles.
// - Pointer indexed jump to accumulator plus data pointer: one byte, three cycles.
// - Branch on accumulator zero or nonzero: two bytes, two or three cycles.
// - Compare accumulator with direct byte, branch if unequal: three bytes, 4/5 cycles.
// - Compare accumulator with immediate, branch if unequal: three bytes, 3/4 cycles.
// - Compare working register with immediate, branch if unequal: three bytes, 3/4.
// - Compare indirect byte with immediate, branch if unequal: four or five cycles.
// - Decrement working register, branch if nonzero: two bytes, two or three cycles.
// - Decrement direct byte, branch if nonzero: three bytes, three or four cycles.
`timescale 1ns/1ps
`default_nettype none
`include "bbi_defs.vh"

module bbi_seq (
   input wire clk,
   input wire nrst,
   output wire [15:0] code_addr,
   input wire [7:0] code_data,
   input wire [7:0] acc,
   input wire carry,
   input wire [15:0] data_pointer,
   output wire [1:0] opnd_kind,
   output wire [7:0] opnd_addr,
   input wire [7:0] opnd_rdata,
   output reg wr_en_q,
   output reg [1:0] wr_kind_q,
   output reg [7:0] wr_addr_q,
   output reg [7:0] wr_data_q,
   output reg carry_we_q,
   output reg carry_d_q,
   output wire instr_done,
   output reg branch_taken_q,
   output reg illegal_q
);

   // ----------------------------------------
   // State and decode
   // ----------------------------------------
   localparam ST_RUN = 2'b01;
   localparam ST_EXTRA = 2'b10;

   reg [1:0] st_q;
   reg [2:0] cnt_q;
   reg [7:0] op_q;
   reg [7:0] b1_q;
   reg [7:0] b2_q;
   reg [15:0] pc_q;
   reg [15:0] start_q;
   reg [15:0] target_q;

   wire [7:0] op;
   wire [7:0] b1;
   wire [7:0] b2;
   wire [1:0] len;
   wire [2:0] base;
   wire [3:0] cls;
   wire [1:0] kind;
   wire inv;
   wire cmp_imm;
   wire cmp_acc;
   wire decide;
   wire [15:0] next_pc;
   wire [15:0] rel_pc;

   // Bytes are used live in the cycle they appear, held afterwards
   assign op = (cnt_q == 3'h0) ? code_data : op_q;
   assign b1 = (cnt_q == 3'h1) ? code_data : b1_q;
   assign b2 = (cnt_q == 3'h2) ? code_data : b2_q;

   bbi_decode u_dec (
      .opcode(op),
      .len(len),
      .base(base),
      .cls(cls),
      .kind(kind),
      .inv(inv),
      .cmp_imm(cmp_imm),
      .cmp_acc(cmp_acc)
   );

   function [15:0] sext8;
      input [7:0] v;
      begin
         sext8 = {{8{v[7]}}, v};
      end
   endfunction

   // Start address is live in cycle 0, held afterwards
   assign next_pc = ((cnt_q == 3'h0) ? pc_q : start_q) + {14'h0000, len};
   assign rel_pc = next_pc + sext8((len == `BBI_LEN3) ? b2 : b1);

   // decision cycle
   // Decision on the last cycle of the untaken count
   assign decide = (st_q == ST_RUN) && (cnt_q == base - 3'h1);
   assign code_addr = pc_q;
   assign opnd_kind = kind;
   assign opnd_addr = (kind == `BBI_K_REG || kind == `BBI_K_IND) ? {5'h00, op[2:0]} : b1;

   // ----------------------------------------
   // Execute
   // ----------------------------------------
   reg taken;
   reg wr_en;
   reg [7:0] wr_data;
   reg c_we;
   reg c_d;
   reg [15:0] target;
   reg [7:0] lhs;
   reg [7:0] rhs;
   reg [7:0] dec;
   reg bitv;

   always @* begin
      taken = 1'b0;
      wr_en = 1'b0;
      wr_data = 8'h00;
      c_we = 1'b0;
      c_d = carry;
      target = rel_pc;
      bitv = opnd_rdata[0] ^ inv;
      lhs = cmp_acc ? acc : opnd_rdata;
      rhs = cmp_imm ? b1 : opnd_rdata;
      dec = opnd_rdata - 8'h01;
      case (cls)
         `BBI_C_AND: begin
            c_we = 1'b1;
            c_d = carry & bitv;
         end
         `BBI_C_OR: begin
            c_we = 1'b1;
            c_d = carry | bitv;
         end
         `BBI_C_MOVC: begin
            c_we = 1'b1;
            c_d = opnd_rdata[0];
         end
         `BBI_C_MOVB: begin
            wr_en = 1'b1;
            wr_data = {7'h00, carry};
         end
         `BBI_C_BCY: taken = carry;
         `BBI_C_BNCY: taken = ~carry;
         `BBI_C_BBIT: taken = opnd_rdata[0];
         `BBI_C_BNBIT: taken = ~opnd_rdata[0];
         `BBI_C_TCLR: begin
            taken = opnd_rdata[0];
            wr_en = opnd_rdata[0];
         end
         `BBI_C_SHORT: taken = 1'b1;
         `BBI_C_JMPI: begin
            taken = 1'b1;
            target = data_pointer + {8'h00, acc};
         end
         `BBI_C_AZ: taken = (acc == 8'h00);
         `BBI_C_ANZ: taken = (acc != 8'h00);
         `BBI_C_CMP: begin
            taken = (lhs != rhs);
            c_we = 1'b1;
            c_d = (lhs < rhs);
         end
         `BBI_C_DEC: begin
            wr_en = 1'b1;
            wr_data = dec;
            taken = (dec != 8'h00);
         end
         default: taken = 1'b0;
      endcase
   end

   assign instr_done = (decide && !taken) || (st_q == ST_EXTRA);

   // ----------------------------------------
   // Sequencing
   // ----------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_RUN;
         cnt_q <= 3'h0;
         op_q <= 8'h00;
         b1_q <= 8'h00;
         b2_q <= 8'h00;
         pc_q <= `BBI_PC_RESET;
         start_q <= `BBI_PC_RESET;
         target_q <= `BBI_PC_RESET;
         wr_en_q <= 1'b0;
         wr_kind_q <= `BBI_K_BIT;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         carry_we_q <= 1'b0;
         carry_d_q <= 1'b0;
         branch_taken_q <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         wr_en_q <= decide & wr_en;
         carry_we_q <= decide & c_we;
         branch_taken_q <= decide & taken;
         illegal_q <= decide & (cls == `BBI_C_ILL);
         if (decide) begin
            wr_kind_q <= kind;
            wr_addr_q <= opnd_addr;
            wr_data_q <= wr_data;
            carry_d_q <= c_d;
         end
         if (cnt_q == 3'h0) begin
            op_q <= code_data;
            start_q <= pc_q;
         end
         if (cnt_q == 3'h1) begin
            b1_q <= code_data;
         end
         if (cnt_q == 3'h2) begin
            b2_q <= code_data;
         end
         case (st_q)
            ST_RUN: begin
               if (decide && taken) begin
                  st_q <= ST_EXTRA;
                  target_q <= target;
                  cnt_q <= cnt_q + 3'h1;
               end else if (decide) begin
                  cnt_q <= 3'h0;
                  pc_q <= next_pc;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
                  // Fetch address steps while operand bytes remain
                  if ({1'b0, cnt_q} < {2'b00, len} - 4'h1) begin
                     pc_q <= pc_q + 16'h0001;
                  end
               end
            end
            ST_EXTRA: begin
               st_q <= ST_RUN;
               cnt_q <= 3'h0;
               pc_q <= target_q;
            end
            default: begin
               st_q <= ST_RUN;
               cnt_q <= 3'h0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// file: verilog/bbi_defs.vh
// Purpose: Shared constants for the bit and branch instruction sequencer
// Assumes: One opcode byte per clock from a zero-latency program store
// Notes: Opcode values are plain defaults and may be re-mapped here
`ifndef BBI_DEFS_VH
`define BBI_DEFS_VH

// ----------------------------------------
// Opcode encodings
// ----------------------------------------
`define BBI_OP_AND_C 8'h82
`define BBI_OP_AND_NC 8'hb0
`define BBI_OP_OR_C 8'h72
`define BBI_OP_OR_NC 8'ha0
`define BBI_OP_BIT_TO_C 8'ha2
`define BBI_OP_C_TO_BIT 8'h92
`define BBI_OP_BR_CY 8'h40
`define BBI_OP_BR_NCY 8'h50
`define BBI_OP_BR_BIT 8'h20
`define BBI_OP_BR_NBIT 8'h30
`define BBI_OP_BR_TCLR 8'h10
`define BBI_OP_SHORT 8'h80
`define BBI_OP_JMPI 8'h73
`define BBI_OP_BR_AZ 8'h60
`define BBI_OP_BR_ANZ 8'h70
`define BBI_OP_CJ_A_DIR 8'hb5
`define BBI_OP_CJ_A_IMM 8'hb4
`define BBI_OP_CJ_IND 7'h5b
`define BBI_OP_CJ_REG 5'h17
`define BBI_OP_DJ_DIR 8'hd5
`define BBI_OP_DJ_REG 5'h1b

// ----------------------------------------
// Instruction classes
// ----------------------------------------
`define BBI_C_AND 4'h0
`define BBI_C_OR 4'h1
`define BBI_C_MOVC 4'h2
`define BBI_C_MOVB 4'h3
`define BBI_C_BCY 4'h4
`define BBI_C_BNCY 4'h5
`define BBI_C_BBIT 4'h6
`define BBI_C_BNBIT 4'h7
`define BBI_C_TCLR 4'h8
`define BBI_C_SHORT 4'h9
`define BBI_C_JMPI 4'ha
`define BBI_C_AZ 4'hb
`define BBI_C_ANZ 4'hc
`define BBI_C_CMP 4'hd
`define BBI_C_DEC 4'he
`define BBI_C_ILL 4'hf

// ----------------------------------------
// Operand kinds
// ----------------------------------------
`define BBI_K_BIT 2'h0
`define BBI_K_DIR 2'h1
`define BBI_K_REG 2'h2
`define BBI_K_IND 2'h3

// ----------------------------------------
// Lengths and cycle counts
// ----------------------------------------
`define BBI_LEN1 2'h1
`define BBI_LEN2 2'h2
`define BBI_LEN3 2'h3
`define BBI_CYC1 3'h1
`define BBI_CYC2 3'h2
`define BBI_CYC3 3'h3
`define BBI_CYC4 3'h4
`define BBI_PC_RESET 16'h0000

`endif

// file: verilog/bbi_decode.v
// Purpose: Opcode decode to length, base cycle count, class and operand kind
// Assumes: Pure combinational, fed from the live or held opcode
// Notes: Base count is the not-taken count; a taken branch adds one
`timescale 1ns/1ps
`default_nettype none
`include "bbi_defs.vh"

module bbi_decode (
   input wire [7:0] opcode,
   output reg [1:0] len,
   output reg [2:0] base,
   output reg [3:0] cls,
   output reg [1:0] kind,
   output reg inv,
   output reg cmp_imm,
   output reg cmp_acc
);

   always @* begin
      len = `BBI_LEN2;
      base = `BBI_CYC2;
      cls = `BBI_C_ILL;
      kind = `BBI_K_BIT;
      inv = 1'b0;
      cmp_imm = 1'b0;
      cmp_acc = 1'b0;
      if (opcode[7:1] == `BBI_OP_CJ_IND) begin
         len = `BBI_LEN3;
         base = `BBI_CYC4;
         cls = `BBI_C_CMP;
         kind = `BBI_K_IND;
         cmp_imm = 1'b1;
      end else if (opcode[7:3] == `BBI_OP_CJ_REG) begin
         len = `BBI_LEN3;
         base = `BBI_CYC3;
         cls = `BBI_C_CMP;
         kind = `BBI_K_REG;
         cmp_imm = 1'b1;
      end else if (opcode[7:3] == `BBI_OP_DJ_REG) begin
         cls = `BBI_C_DEC;
         kind = `BBI_K_REG;
      end else begin
         case (opcode)
            `BBI_OP_AND_C: cls = `BBI_C_AND;
            `BBI_OP_AND_NC: begin
               cls = `BBI_C_AND;
               inv = 1'b1;
            end
            `BBI_OP_OR_C: cls = `BBI_C_OR;
            `BBI_OP_OR_NC: begin
               cls = `BBI_C_OR;
               inv = 1'b1;
            end
            `BBI_OP_BIT_TO_C: cls = `BBI_C_MOVC;
            `BBI_OP_C_TO_BIT: cls = `BBI_C_MOVB;
            `BBI_OP_BR_CY: cls = `BBI_C_BCY;
            `BBI_OP_BR_NCY: cls = `BBI_C_BNCY;
            `BBI_OP_SHORT: cls = `BBI_C_SHORT;
            `BBI_OP_BR_AZ: cls = `BBI_C_AZ;
            `BBI_OP_BR_ANZ: cls = `BBI_C_ANZ;
            `BBI_OP_BR_BIT, `BBI_OP_BR_NBIT, `BBI_OP_BR_TCLR: begin
               len = `BBI_LEN3;
               base = `BBI_CYC3;
               cls = (opcode == `BBI_OP_BR_BIT) ? `BBI_C_BBIT :
                     (opcode == `BBI_OP_BR_NBIT) ? `BBI_C_BNBIT : `BBI_C_TCLR;
            end
            `BBI_OP_JMPI: begin
               len = `BBI_LEN1;
               cls = `BBI_C_JMPI;
            end
            `BBI_OP_CJ_A_DIR: begin
               len = `BBI_LEN3;
               base = `BBI_CYC4;
               cls = `BBI_C_CMP;
               kind = `BBI_K_DIR;
               cmp_acc = 1'b1;
            end
            `BBI_OP_CJ_A_IMM: begin
               len = `BBI_LEN3;
               base = `BBI_CYC3;
               cls = `BBI_C_CMP;
               kind = `BBI_K_DIR;
               cmp_acc = 1'b1;
               cmp_imm = 1'b1;
            end
            `BBI_OP_DJ_DIR: begin
               len = `BBI_LEN3;
               base = `BBI_CYC3;
               cls = `BBI_C_DEC;
               kind = `BBI_K_DIR;
            end
            default: begin
               // Unknown opcodes skip one byte in one cycle
               len = `BBI_LEN1;
               base = `BBI_CYC1;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// file: verif/bbi_seq_sva.sv
// Purpose: Cycle count checks for bbi_seq
// Assumes: One clock, nrst async active low
// Notes: First cycle of each instruction is tracked from instr_done
`timescale 1ns/1ps
`default_nettype none
`include "bbi_defs.vh"
module bbi_seq_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] code_data,
   input wire logic instr_done,
   input wire logic branch_taken_q
);
   logic first_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) first_q <= 1'b1;
      else first_q <= instr_done;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ----
   // Instruction lengths in cycles
   // ----
   sequence s_c2; !instr_done ##1 instr_done; endsequence
   sequence s_c3; !instr_done [*2] ##1 instr_done; endsequence
   sequence s_c4; !instr_done [*3] ##1 instr_done; endsequence
   sequence s_c5; !instr_done [*4] ##1 instr_done; endsequence
   a_bit_two_cyc:
   assert property (first_q && code_data inside {`BBI_OP_AND_C, `BBI_OP_AND_NC, `BBI_OP_OR_C,
      `BBI_OP_OR_NC, `BBI_OP_BIT_TO_C, `BBI_OP_C_TO_BIT} |-> s_c2) else $error("bit op length");
   a_carry_br_cyc:
   assert property (first_q && code_data inside {`BBI_OP_BR_CY, `BBI_OP_BR_NCY}
      |-> s_c2 or (s_c3 ##0 branch_taken_q)) else $error("carry branch length");
   a_bit_br_cyc:
   assert property (first_q && code_data inside {`BBI_OP_BR_BIT, `BBI_OP_BR_NBIT, `BBI_OP_BR_TCLR}
      |-> s_c3 or (s_c4 ##0 branch_taken_q)) else $error("bit branch length");
   a_jump_three_cyc:
   assert property (first_q && code_data inside {`BBI_OP_SHORT, `BBI_OP_JMPI} |-> s_c3)
      else $error("jump length");
   a_short_br_cyc:
   assert property (first_q && (code_data inside {`BBI_OP_BR_AZ, `BBI_OP_BR_ANZ}
      || code_data[7:3] == `BBI_OP_DJ_REG) |-> s_c2 or (s_c3 ##0 branch_taken_q))
      else $error("short branch length");
   a_imm_br_cyc:
   assert property (first_q && (code_data inside {`BBI_OP_CJ_A_IMM, `BBI_OP_DJ_DIR}
      || code_data[7:3] == `BBI_OP_CJ_REG) |-> s_c3 or (s_c4 ##0 branch_taken_q))
      else $error("compare branch length");
   a_mem_cmp_cyc:
   assert property (first_q && (code_data == `BBI_OP_CJ_A_DIR
      || code_data[7:1] == `BBI_OP_CJ_IND) |-> s_c4 or (s_c5 ##0 branch_taken_q))
      else $error("memory compare length");
   a_taken_at_done:
   assert property (branch_taken_q |-> instr_done) else $error("taken outside last cycle");
endmodule
bind bbi_seq bbi_seq_chk bbi_seq_chk_inst (.clk(clk), .nrst(nrst), .code_data(code_data),
   .instr_done(instr_done), .branch_taken_q(branch_taken_q));
`default_nettype wire

// file: verif/bbi_mem.sv
// Purpose: Program store and operand space beside bbi_seq
// Assumes: Zero-latency reads, writes at the clock edge
// Notes: Only the low code address byte is decoded, so code aliases
`timescale 1ns/1ps
`default_nettype none
module bbi_mem (
   input wire logic clk,
   input wire logic [15:0] code_addr,
   output logic [7:0] code_data,
   input wire logic [1:0] opnd_kind,
   input wire logic [7:0] opnd_addr,
   output logic [7:0] opnd_rdata,
   input wire logic wr_en_q,
   input wire logic [1:0] wr_kind_q,
   input wire logic [7:0] wr_addr_q,
   input wire logic [7:0] wr_data_q
);
   logic [7:0] code [0:255];
   logic [7:0] dat [0:1023];
   logic [7:0] ptr;
   assign code_data = code[code_addr[7:0]];
   // Indirect reads go through the selected working register
   assign ptr = dat[{2'h2, 7'h00, opnd_addr[0]}];
   assign opnd_rdata = (opnd_kind == 2'h3) ? dat[{2'h1, ptr}] : dat[{opnd_kind, opnd_addr}];
   always @(posedge clk) begin
      if (wr_en_q) dat[{wr_kind_q, wr_addr_q}] <= wr_data_q;
   end
endmodule
`default_nettype wire

// file: verif/tb_bbi_seq.sv
// Purpose: Self-checking bench for bbi_seq
// Assumes: bbi_mem answers in the same cycle
// Notes: Every scenario starts from reset at address zero
`timescale 1ns/1ps
`default_nettype none
`include "bbi_defs.vh"
module tb_bbi_seq;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic carry = 1'b0;
   logic cy;
   logic [7:0] acc = 8'h00;
   logic [15:0] data_pointer = 16'h0000;
   integer failures = 0;
   integer tests_run = 0;
   wire [15:0] code_addr;
   wire [7:0] code_data, opnd_addr, opnd_rdata, wr_addr_q, wr_data_q;
   wire [1:0] opnd_kind, wr_kind_q;
   wire wr_en_q, carry_we_q, carry_d_q, instr_done, branch_taken_q, illegal_q;
   bbi_seq bbi_seq_inst (.clk(clk), .nrst(nrst), .code_addr(code_addr),
      .code_data(code_data), .acc(acc), .carry(carry), .data_pointer(data_pointer),
      .opnd_kind(opnd_kind), .opnd_addr(opnd_addr), .opnd_rdata(opnd_rdata),
      .wr_en_q(wr_en_q), .wr_kind_q(wr_kind_q), .wr_addr_q(wr_addr_q),
      .wr_data_q(wr_data_q), .carry_we_q(carry_we_q), .carry_d_q(carry_d_q),
      .instr_done(instr_done), .branch_taken_q(branch_taken_q), .illegal_q(illegal_q));
   bbi_mem bbi_mem_inst (.clk(clk), .code_addr(code_addr), .code_data(code_data),
      .opnd_kind(opnd_kind), .opnd_addr(opnd_addr), .opnd_rdata(opnd_rdata),
      .wr_en_q(wr_en_q), .wr_kind_q(wr_kind_q), .wr_addr_q(wr_addr_q),
      .wr_data_q(wr_data_q));
   initial begin
      forever #4 clk = ~clk;
   end
   always @(negedge clk) begin
      if (carry_we_q === 1'b1) cy = carry_d_q;
   end
   // ----
   // Helpers
   // ----
   task step;
      begin
         @(negedge clk);
         #1;
      end
   endtask
   task fail(input string m);
      begin
         failures = failures + 1;
         $display("Error at %0t: %s", $time, m);
      end
   endtask
   task chk_cyc(input integer g, input integer e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) fail("cycle count");
      end
   endtask
   task chk_addr(input logic [15:0] g, input logic [15:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) fail("next address");
      end
   endtask
   task chk_dat(input logic [7:0] g, input logic [7:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) fail("data value");
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, failures);
         if (failures == 0 && tests_run > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task rst(input integer n);
      begin
         @(negedge clk);
         nrst = 1'b0;
         repeat (n) @(negedge clk);
         nrst = 1'b1;
         #1;
      end
   endtask
   task put(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1,
      input logic [7:0] b2);
      begin
         bbi_mem_inst.code[a] = b0;
         bbi_mem_inst.code[8'(a + 8'h01)] = b1;
         bbi_mem_inst.code[8'(a + 8'h02)] = b2;
      end
   endtask
   // Counts cycles to instr_done, then checks where fetch goes next
   task exec(input integer n, input logic [15:0] nxt);
      integer k;
      begin
         k = 1;
         while (instr_done !== 1'b1 && k < 9) begin
            step;
            k = k + 1;
         end
         if (k == 9) begin
            fail("no completion");
            conclude;
         end else begin
            chk_cyc(k, n);
            step;
            chk_addr(code_addr, nxt);
         end
      end
   endtask
   // ----
   // Scenarios
   // ----
   task t_bitops;
      logic [7:0] ops [0:4];
      logic [4:0] cin;
      logic [4:0] cexp;
      integer i;
      begin
         ops = '{`BBI_OP_AND_C, `BBI_OP_AND_NC, `BBI_OP_OR_C, `BBI_OP_OR_NC, `BBI_OP_BIT_TO_C};
         cin = 5'b10011;
         cexp = 5'b01010;
         for (i = 0; i < 5; i = i + 1) put(8'(2 * i), ops[i], 8'h05, 8'h00);
         put(8'h0a, `BBI_OP_C_TO_BIT, 8'h06, 8'h00);
         bbi_mem_inst.dat[5] = 8'h00;
         bbi_mem_inst.dat[6] = 8'h00;
         carry = 1'b1;
         rst(5);
         for (i = 0; i < 5; i = i + 1) begin
            cy = 1'bx;
            carry = cin[i];
            exec(2, 16'(2 * i + 2));
            chk_dat({7'h00, cy}, {7'h00, cexp[i]});
         end
         exec(2, 16'h000c);
         step;
         chk_dat({7'h00, bbi_mem_inst.dat[6][0]}, 8'h01);
         $display("t_bitops done");
      end
   endtask
   task t_jumps;
      begin
         put(8'h00, `BBI_OP_BR_CY, 8'h10, 8'h00);
         put(8'h12, `BBI_OP_BR_NCY, 8'h33, 8'h00);
         put(8'h14, `BBI_OP_SHORT, 8'hf0, 8'h00);
         put(8'h06, `BBI_OP_JMPI, 8'h00, 8'h00);
         // Unknown opcode at the pointer jump target
         put(8'h30, 8'h00, 8'h00, 8'h00);
         carry = 1'b1;
         acc = 8'h20;
         data_pointer = 16'h0010;
         rst(2);
         exec(3, 16'h0012);
         exec(2, 16'h0014);
         exec(3, 16'h0006);
         exec(3, 16'h0030);
         exec(1, 16'h0031);
         chk_dat({7'h00, illegal_q}, 8'h01);
         $display("t_jumps done");
      end
   endtask
   task t_bitbr;
      begin
         put(8'h00, `BBI_OP_BR_BIT, 8'h05, 8'h04);
         put(8'h07, `BBI_OP_BR_NBIT, 8'h05, 8'h40);
         put(8'h0a, `BBI_OP_BR_TCLR, 8'h05, 8'h02);
         put(8'h0f, `BBI_OP_BR_TCLR, 8'h05, 8'h40);
         bbi_mem_inst.dat[5] = 8'h01;
         rst(2);
         exec(4, 16'h0007);
         exec(3, 16'h000a);
         exec(4, 16'h000f);
         chk_dat({7'h00, bbi_mem_inst.dat[5][0]}, 8'h00);
         exec(3, 16'h0012);
         $display("t_bitbr done");
      end
   endtask
   task t_accbr;
      begin
         put(8'h00, `BBI_OP_BR_AZ, 8'h04, 8'h00);
         put(8'h06, `BBI_OP_BR_ANZ, 8'h40, 8'h00);
         put(8'h08, {`BBI_OP_DJ_REG, 3'h3}, 8'h40, 8'h00);
         put(8'h0a, {`BBI_OP_DJ_REG, 3'h3}, 8'hfe, 8'h00);
         acc = 8'h00;
         bbi_mem_inst.dat[10'h203] = 8'h01;
         rst(2);
         exec(3, 16'h0006);
         exec(2, 16'h0008);
         exec(2, 16'h000a);
         exec(3, 16'h000a);
         chk_dat(bbi_mem_inst.dat[10'h203], 8'hff);
         $display("t_accbr done");
      end
   endtask
   task t_cmp;
      begin
         put(8'h00, `BBI_OP_CJ_A_DIR, 8'h40, 8'h40);
         put(8'h03, `BBI_OP_CJ_A_IMM, 8'h34, 8'h02);
         put(8'h08, {`BBI_OP_CJ_REG, 3'h2}, 8'h05, 8'h40);
         put(8'h0b, {`BBI_OP_CJ_IND, 1'b1}, 8'h07, 8'h00);
         put(8'h0e, `BBI_OP_DJ_DIR, 8'h60, 8'h00);
         bbi_mem_inst.dat[10'h140] = 8'h33;
         bbi_mem_inst.dat[10'h202] = 8'h05;
         bbi_mem_inst.dat[10'h201] = 8'h50;
         bbi_mem_inst.dat[10'h150] = 8'h09;
         bbi_mem_inst.dat[10'h160] = 8'h03;
         acc = 8'h33;
         cy = 1'bx;
         rst(2);
         exec(4, 16'h0003);
         chk_dat({7'h00, cy}, 8'h00);
         exec(4, 16'h0008);
         chk_dat({7'h00, cy}, 8'h01);
         exec(3, 16'h000b);
         cy = 1'bx;
         exec(5, 16'h000e);
         chk_dat({7'h00, cy}, 8'h00);
         exec(4, 16'h0011);
         chk_dat(bbi_mem_inst.dat[10'h160], 8'h02);
         $display("t_cmp done");
      end
   endtask
   initial begin
      t_bitops;
      t_jumps;
      t_bitbr;
      t_accbr;
      t_cmp;
      conclude;
   end
endmodule
`default_nettype wire
